// file: i2c_port_pkg.sv
package i2c_port_pkg;
    // device address bytes with direction bit
    localparam logic [7:0] DEV_WR_ADDR = 8'hd0;
    localparam logic [7:0] DEV_RD_ADDR = 8'hd1;

    // clock registers reachable in low-power mode
    localparam logic [7:0] CLOCK_RATIO_CTRL_OFS = 8'h01;
    localparam logic [7:0] MASTER_CLOCK_CTRL_OFS = 8'h02;
    localparam logic [7:0] AUX_CLOCK_CTRL_OFS = 8'h03;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;
    localparam logic [7:0] RESTRICTED_READ_VAL = 8'h00;

    // host controller registers (apb)
    localparam logic [31:0] HOST_CMD_OFS = 32'h0000_0000;
    localparam logic [31:0] HOST_STAT_OFS = 32'h0000_0004;
    localparam int CMD_START_BIT = 0;
    localparam int CMD_STOP_BIT = 1;
    localparam int CMD_READ_BIT = 2;
    localparam int CMD_NACK_BIT = 3;
    localparam int CMD_DATA_LSB = 8;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NACK_BIT = 1;
    localparam int STAT_DATA_LSB = 8;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_PERIOD_NS = 2000;
    localparam int SCL_QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam int STRAP_SETTLE_CYC = 3;
endpackage

// file: i2c_link_if.sv
`timescale 1ns/1ps
interface i2c_link_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // open-drain wired-and with pull-ups
    assign scl = (host_scl_oe && !host_scl_o) ? 1'b0 : 1'b1;
    assign sda = ((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o)) ? 1'b0 : 1'b1;

    modport device (
        input scl,
        input sda,
        output dev_sda_o,
        output dev_sda_oe
    );

    modport host (
        input sda,
        output host_scl_o,
        output host_scl_oe,
        output host_sda_o,
        output host_sda_oe
    );
endinterface

// file: i2c_reg_port.sv
`timescale 1ns/1ps
// Overview of operation
// - first byte d0 write, d1 read only
// - second write byte loads register pointer
// - data bytes stored at successive addresses
// - write accepts bytes until stop condition
// - acknowledge every received byte except a foreign address byte
// - host sets pointer with data-less write
// - host restarts with read address byte
// - read returns pointer register then successive
// - low-power mode: only registers 01-03 accessible
// - low-power mode: one register, no increment
// - low-power scl below tenth of clock
// - strap at power-on sets low-power mode
module i2c_reg_port
    import i2c_port_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // serial link
    i2c_link_if.device link,
    // strap and status
    input wire logic low_power_strap_i,
    output logic standby_o,
    // register write notification
    output logic reg_wr_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_MACK = 3'b100,
        ST_TXNEXT = 3'b101
    } port_state_e;

    port_state_e st_reg;
    logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
    logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
    logic strap_s1_reg, strap_s2_reg;
    logic [1:0] settle_reg;
    logic standby_reg;
    logic [3:0] bit_cnt_reg;
    logic [1:0] byte_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic [7:0] ptr_reg;
    logic rd_reg;
    logic sda_oe_reg;
    logic reg_wr_reg;
    logic [7:0] reg_addr_reg;
    logic [7:0] reg_wdata_reg;
    logic [7:0] regs_mem [0:255];

    logic scl_rise, scl_fall, start_cond, stop_cond;
    logic byte_end, ptr_permitted, write_ok, wr_hit, tx_load;
    logic [7:0] rd_val;

    // two-stage synchronisers for pins
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            scl_s3_reg <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_s3_reg <= 1'b1;
            strap_s1_reg <= 1'b0;
            strap_s2_reg <= 1'b0;
        end else begin
            scl_s1_reg <= link.scl;
            scl_s2_reg <= scl_s1_reg;
            scl_s3_reg <= scl_s2_reg;
            sda_s1_reg <= link.sda;
            sda_s2_reg <= sda_s1_reg;
            sda_s3_reg <= sda_s2_reg;
            strap_s1_reg <= low_power_strap_i;
            strap_s2_reg <= strap_s1_reg;
        end
    end

    // strap is caught once the synchroniser has settled after reset
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            settle_reg <= 2'b00;
            standby_reg <= 1'b0;
        end else if (settle_reg != 2'(STRAP_SETTLE_CYC)) begin
            settle_reg <= settle_reg + 2'd1;
            if (settle_reg == 2'(STRAP_SETTLE_CYC - 1)) begin
                standby_reg <= strap_s2_reg;
            end
        end
    end

    assign scl_rise = scl_s2_reg && !scl_s3_reg;
    assign scl_fall = !scl_s2_reg && scl_s3_reg;
    assign start_cond = scl_s2_reg && scl_s3_reg && !sda_s2_reg && sda_s3_reg;
    assign stop_cond = scl_s2_reg && scl_s3_reg && sda_s2_reg && !sda_s3_reg;
    assign byte_end = scl_fall && (st_reg == ST_RX) && (bit_cnt_reg == 4'd8);

    always_comb begin
        ptr_permitted = (ptr_reg == CLOCK_RATIO_CTRL_OFS) || (ptr_reg == MASTER_CLOCK_CTRL_OFS)
            || (ptr_reg == AUX_CLOCK_CTRL_OFS);
        if (standby_reg) begin
            write_ok = (byte_cnt_reg == 2'd2) && ptr_permitted;
            rd_val = ptr_permitted ? regs_mem[ptr_reg] : RESTRICTED_READ_VAL;
        end else begin
            write_ok = 1'b1;
            rd_val = regs_mem[ptr_reg];
        end
    end

    assign wr_hit = byte_end && !rd_reg && (byte_cnt_reg >= 2'd2) && write_ok;
    assign tx_load = scl_fall && ((st_reg == ST_ACK && rd_reg) || st_reg == ST_TXNEXT);

    // register array
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < 256; i++) begin
                regs_mem[i] <= REG_RESET_VAL;
            end
        end else if (wr_hit) begin
            regs_mem[ptr_reg] <= shift_reg;
        end
    end

    // write notification towards the core
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            reg_wr_reg <= 1'b0;
            reg_addr_reg <= 8'h00;
            reg_wdata_reg <= 8'h00;
        end else begin
            reg_wr_reg <= wr_hit;
            if (wr_hit) begin
                reg_addr_reg <= ptr_reg;
                reg_wdata_reg <= shift_reg;
            end
        end
    end

    // register pointer
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ptr_reg <= 8'h00;
        end else if (byte_end && !rd_reg && byte_cnt_reg == 2'd1) begin
            ptr_reg <= shift_reg;
        end else if ((wr_hit || tx_load) && !standby_reg) begin
            ptr_reg <= ptr_reg + 8'd1;
        end
    end

    // byte-level protocol engine
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_reg <= ST_IDLE;
            bit_cnt_reg <= 4'd0;
            byte_cnt_reg <= 2'd0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            rd_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else if (start_cond) begin
            st_reg <= ST_RX;
            bit_cnt_reg <= 4'd0;
            byte_cnt_reg <= 2'd0;
            rd_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else if (stop_cond) begin
            st_reg <= ST_IDLE;
            sda_oe_reg <= 1'b0;
        end else begin
            case (st_reg)
                ST_IDLE: begin
                    sda_oe_reg <= 1'b0;
                end
                ST_RX: begin
                    if (scl_rise && bit_cnt_reg != 4'd8) begin
                        shift_reg <= {shift_reg[6:0], sda_s2_reg};
                        bit_cnt_reg <= bit_cnt_reg + 4'd1;
                    end else if (byte_end) begin
                        bit_cnt_reg <= 4'd0;
                        if (byte_cnt_reg != 2'd3) begin
                            byte_cnt_reg <= byte_cnt_reg + 2'd1;
                        end
                        if (byte_cnt_reg == 2'd0 && shift_reg == DEV_RD_ADDR) begin
                            rd_reg <= 1'b1;
                            st_reg <= ST_ACK;
                            sda_oe_reg <= 1'b1;
                        end else if (byte_cnt_reg == 2'd0 && shift_reg != DEV_WR_ADDR) begin
                            st_reg <= ST_IDLE;
                        end else begin
                            st_reg <= ST_ACK;
                            sda_oe_reg <= 1'b1;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (rd_reg) begin
                            tx_reg <= rd_val;
                            sda_oe_reg <= !rd_val[7];
                            bit_cnt_reg <= 4'd0;
                            st_reg <= ST_TX;
                        end else begin
                            sda_oe_reg <= 1'b0;
                            st_reg <= ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_reg == 4'd7) begin
                            sda_oe_reg <= 1'b0;
                            st_reg <= ST_MACK;
                        end else begin
                            tx_reg <= {tx_reg[6:0], 1'b0};
                            sda_oe_reg <= !tx_reg[6];
                            bit_cnt_reg <= bit_cnt_reg + 4'd1;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        st_reg <= sda_s2_reg ? ST_IDLE : ST_TXNEXT;
                    end
                end
                ST_TXNEXT: begin
                    if (scl_fall) begin
                        tx_reg <= rd_val;
                        sda_oe_reg <= !rd_val[7];
                        bit_cnt_reg <= 4'd0;
                        st_reg <= ST_TX;
                    end
                end
                default: begin
                    st_reg <= ST_IDLE;
                end
            endcase
        end
    end

    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe = sda_oe_reg;
    assign standby_o = standby_reg;
    assign reg_wr_o = reg_wr_reg;
    assign reg_addr_o = reg_addr_reg;
    assign reg_wdata_o = reg_wdata_reg;
endmodule

// file: i2c_host_ctrl.sv
`timescale 1ns/1ps
module i2c_host_ctrl
    import i2c_port_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // apb slave
    input wire logic [31:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // serial link
    i2c_link_if.host link
);
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_START = 2'b01,
        H_BIT = 2'b10,
        H_STOP = 2'b11
    } host_state_e;

    host_state_e st_reg;
    logic pready_reg, pslverr_reg;
    logic [31:0] prdata_reg;
    logic sda_s1_reg, sda_s2_reg;
    logic [15:0] qcnt_reg;
    logic [1:0] q_reg;
    logic [3:0] bit_idx_reg;
    logic busy_reg, nack_reg, stop_reg, read_reg, rnack_reg;
    logic [7:0] tx_reg, rx_reg;
    logic scl_oe_reg, sda_oe_reg;
    logic access, cmd_wr, tick;

    assign access = psel_i && penable_i && !pready_reg;
    assign cmd_wr = psel_i && penable_i && pready_reg && pwrite_i && (paddr_i == HOST_CMD_OFS)
        && !busy_reg;
    assign tick = (st_reg != H_IDLE) && (qcnt_reg == 16'(SCL_QTR_CYC - 1));

    // apb: one wait state, then answer
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= access;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            if (access) begin
                if (paddr_i == HOST_STAT_OFS) begin
                    prdata_reg[STAT_BUSY_BIT] <= busy_reg;
                    prdata_reg[STAT_NACK_BIT] <= nack_reg;
                    prdata_reg[STAT_DATA_LSB +: 8] <= rx_reg;
                end else if (paddr_i != HOST_CMD_OFS) begin
                    pslverr_reg <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
        end else begin
            sda_s1_reg <= link.sda;
            sda_s2_reg <= sda_s1_reg;
        end
    end

    // quarter-bit divider for the serial clock
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || st_reg == H_IDLE || tick) begin
            qcnt_reg <= 16'h0000;
        end else begin
            qcnt_reg <= qcnt_reg + 16'h0001;
        end
    end

    // bit sequencer
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_reg <= H_IDLE;
            q_reg <= 2'd0;
            bit_idx_reg <= 4'd0;
            busy_reg <= 1'b0;
            nack_reg <= 1'b0;
            stop_reg <= 1'b0;
            read_reg <= 1'b0;
            rnack_reg <= 1'b0;
            tx_reg <= 8'h00;
            rx_reg <= 8'h00;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else if (cmd_wr) begin
            busy_reg <= 1'b1;
            stop_reg <= pwdata_i[CMD_STOP_BIT];
            read_reg <= pwdata_i[CMD_READ_BIT];
            rnack_reg <= pwdata_i[CMD_NACK_BIT];
            tx_reg <= pwdata_i[CMD_DATA_LSB +: 8];
            q_reg <= 2'd0;
            bit_idx_reg <= 4'd0;
            st_reg <= pwdata_i[CMD_START_BIT] ? H_START : H_BIT;
        end else if (tick) begin
            q_reg <= q_reg + 2'd1;
            case (st_reg)
                H_START: begin
                    if (q_reg == 2'd0) sda_oe_reg <= 1'b0;
                    if (q_reg == 2'd1) scl_oe_reg <= 1'b0;
                    if (q_reg == 2'd2) sda_oe_reg <= 1'b1;
                    if (q_reg == 2'd3) begin
                        scl_oe_reg <= 1'b1;
                        st_reg <= H_BIT;
                    end
                end
                H_BIT: begin
                    if (q_reg == 2'd0) begin
                        if (bit_idx_reg != 4'd8) begin
                            sda_oe_reg <= !read_reg && !tx_reg[7];
                        end else begin
                            sda_oe_reg <= read_reg && !rnack_reg;
                        end
                    end
                    if (q_reg == 2'd1) scl_oe_reg <= 1'b0;
                    if (q_reg == 2'd2) begin
                        if (bit_idx_reg != 4'd8) begin
                            rx_reg <= {rx_reg[6:0], sda_s2_reg};
                        end else if (!read_reg) begin
                            nack_reg <= sda_s2_reg;
                        end
                    end
                    if (q_reg == 2'd3) begin
                        scl_oe_reg <= 1'b1;
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        bit_idx_reg <= bit_idx_reg + 4'd1;
                        if (bit_idx_reg == 4'd8) begin
                            st_reg <= stop_reg ? H_STOP : H_IDLE;
                            busy_reg <= stop_reg;
                        end
                    end
                end
                H_STOP: begin
                    if (q_reg == 2'd0) sda_oe_reg <= 1'b1;
                    if (q_reg == 2'd1) scl_oe_reg <= 1'b0;
                    if (q_reg == 2'd2) sda_oe_reg <= 1'b0;
                    if (q_reg == 2'd3) begin
                        st_reg <= H_IDLE;
                        busy_reg <= 1'b0;
                    end
                end
                default: begin
                    st_reg <= H_IDLE;
                end
            endcase
        end
    end

    assign link.host_scl_o = 1'b0;
    assign link.host_scl_oe = scl_oe_reg;
    assign link.host_sda_o = 1'b0;
    assign link.host_sda_oe = sda_oe_reg;
    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
endmodule

// file: i2c_link_checker.sv
`timescale 1ns/1ps
module i2c_link_checker
    import i2c_port_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // link wires
    input wire logic host_scl_o,
    input wire logic host_scl_oe,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    logic scl_q, sda_q, live, first_byte, wr_xfer, rise, ack_slot, dev_hit;
    logic [3:0] bit_cnt;
    logic [7:0] shift;

    assign rise = scl && !scl_q;
    assign ack_slot = rise && live && (bit_cnt == 4'h8);
    assign dev_hit = (shift == DEV_WR_ADDR) || (shift == DEV_RD_ADDR);

    always_ff @(posedge clk_i) begin
        scl_q <= scl;
        sda_q <= sda;
    end

    // follows the frame: start opens it, each scl rise except the ninth (ack slot) shifts in one bit
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            live <= 1'b0;
        end else if (scl && scl_q && sda_q && !sda) begin
            live <= 1'b1;
            first_byte <= 1'b1;
            bit_cnt <= 4'h0;
        end else if (scl && scl_q && !sda_q && sda) begin
            live <= 1'b0;
        end else if (ack_slot) begin
            bit_cnt <= 4'h0;
            first_byte <= 1'b0;
            wr_xfer <= first_byte ? (shift == DEV_WR_ADDR) : wr_xfer;
        end else if (rise) begin
            bit_cnt <= bit_cnt + 4'h1;
            shift <= {shift[6:0], sda};
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    AST_RESET_IDLE: assert property (disable iff (1'b0)
        sys_rst_i |=> !host_scl_oe && !host_sda_oe && !dev_sda_oe)
        else $error("link not released after reset");
    AST_OPEN_DRAIN: assert property (!host_scl_o && !host_sda_o && !dev_sda_o)
        else $error("open-drain data level not low");
    AST_ADDR_ACK: assert property (ack_slot && first_byte && dev_hit |-> dev_sda_oe)
        else $error("own address byte not acknowledged");
    AST_ADDR_IGNORE: assert property (ack_slot && first_byte && !dev_hit
        |-> !dev_sda_oe)
        else $error("foreign address byte acknowledged");
    AST_WRITE_ACK: assert property (ack_slot && !first_byte && wr_xfer |-> dev_sda_oe)
        else $error("written byte not acknowledged");
    AST_DEV_SDA_STEADY: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl))
        else $error("device changed data while clock high");
    AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl [*5])
        else $error("clock high phase too short");
    AST_SCL_LOW_MIN: assert property ($fell(scl) |-> !scl [*5])
        else $error("clock low phase too short");
    AST_START_CLOCKS: assert property ($rose(host_sda_oe) && scl |-> ##[1:300] !scl)
        else $error("no clock after start");
    AST_STOP_IDLE: assert property ($fell(host_sda_oe) && scl
        |=> (scl && sda && !dev_sda_oe) [*8])
        else $error("bus not idle after stop");

    cover property (ack_slot && !first_byte && wr_xfer);
    cover property (ack_slot && first_byte && !dev_hit);
    cover property (ack_slot && !first_byte && !wr_xfer);
endmodule

// file: i2c_register_access_port_tb.sv
`timescale 1ns/1ps
module i2c_register_access_port_tb;
    import i2c_port_pkg::*;
    localparam logic [7:0] F_S = 8'h01 << CMD_START_BIT;
    localparam logic [7:0] F_P = 8'h01 << CMD_STOP_BIT;
    localparam logic [7:0] F_R = 8'h01 << CMD_READ_BIT;
    localparam logic [7:0] F_N = 8'h01 << CMD_NACK_BIT;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic strap = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, standby, reg_wr;
    logic [7:0] reg_addr, reg_wdata;
    logic [15:0] wq[$];
    int err_count = 0;
    int checked = 0;

    always #5 clk = ~clk;

    i2c_link_if link();
    i2c_reg_port u_i2c_reg_port (.clk_i(clk), .sys_rst_i(sys_rst), .link(link),
        .low_power_strap_i(strap), .standby_o(standby), .reg_wr_o(reg_wr),
        .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));
    i2c_host_ctrl u_i2c_host_ctrl (.clk_i(clk), .sys_rst_i(sys_rst), .paddr_i(paddr),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .link(link));
    i2c_link_checker u_i2c_link_checker (.clk_i(clk), .sys_rst_i(sys_rst),
        .host_scl_o(link.host_scl_o), .host_scl_oe(link.host_scl_oe),
        .host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe),
        .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe),
        .scl(link.scl), .sda(link.sda));

    // collect every register store the device reports
    always @(posedge clk) begin
        if (reg_wr === 1'b1) begin
            wq.push_back({reg_addr, reg_wdata});
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        if (err_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one byte on the link, then poll until the host is idle again
    task automatic xfer(input logic [7:0] f, input logic [7:0] b, output logic [31:0] st);
        logic e;
        apb(1'b1, HOST_CMD_OFS, {16'h0000, b, f}, st, e);
        do begin
            apb(1'b0, HOST_STAT_OFS, 32'h0000_0000, st, e);
        end while (st[STAT_BUSY_BIT] !== 1'b0);
    endtask

    task automatic wbyte(input logic [7:0] f, input logic [7:0] b, input logic nk);
        logic [31:0] st;
        xfer(f, b, st);
        chk("nack", 32'(st[STAT_NACK_BIT]), 32'(nk));
    endtask

    task automatic rbyte(input logic [7:0] f, input logic [7:0] exp);
        logic [31:0] st;
        xfer(f | F_R, 8'h00, st);
        chk("rdata", 32'(st[STAT_DATA_LSB +: 8]), 32'(exp));
    endtask

    task automatic do_reset(input logic s);
        sys_rst <= 1'b1;
        strap <= s;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk);
        chk("standby", 32'(standby), 32'(s));
        chk("pready", 32'(pready), 32'h0000_0000);
    endtask

    task automatic t_apb_map();
        logic [31:0] q;
        logic e;
        apb(1'b0, 32'h0000_0008, 32'h0000_0000, q, e);
        chk("slverr", 32'(e), 32'h0000_0001);
        chk("unmapped", q, 32'h0000_0000);
    endtask

    task automatic t_bad_addr();
        wq.delete();
        wbyte(F_S | F_P, 8'hd2, 1'b1);
        chk("bad_count", 32'(wq.size()), 32'h0000_0000);
    endtask

    // pointer at the top of the map so the second byte wraps
    task automatic t_write();
        wq.delete();
        wbyte(F_S, DEV_WR_ADDR, 1'b0);
        wbyte(8'h00, 8'hff, 1'b0);
        wbyte(8'h00, 8'haa, 1'b0);
        wbyte(F_P, 8'hbb, 1'b0);
        chk("wr_count", 32'(wq.size()), 32'h0000_0002);
        chk("wr_first", 32'(wq[0]), 32'h0000_ffaa);
        chk("wr_next", 32'(wq[1]), 32'h0000_00bb);
    endtask

    task automatic t_read();
        wq.delete();
        wbyte(F_S, DEV_WR_ADDR, 1'b0);
        wbyte(F_P, 8'hff, 1'b0);
        wbyte(F_S, DEV_RD_ADDR, 1'b0);
        rbyte(8'h00, 8'haa);
        rbyte(F_N | F_P, 8'hbb);
        chk("rd_count", 32'(wq.size()), 32'h0000_0000);
    endtask

    // two data bytes in low-power mode: only the first may land, at the pointer
    task automatic t_standby();
        do_reset(1'b1);
        wq.delete();
        wbyte(F_S, DEV_WR_ADDR, 1'b0);
        wbyte(8'h00, MASTER_CLOCK_CTRL_OFS, 1'b0);
        wbyte(8'h00, 8'h55, 1'b0);
        wbyte(F_P, 8'h66, 1'b0);
        chk("lp_count", 32'(wq.size()), 32'h0000_0001);
        chk("lp_store", 32'(wq[0]), {16'h0000, MASTER_CLOCK_CTRL_OFS, 8'h55});
    endtask

    // low-power mode: foreign address neither stored nor readable, reads never advance
    task automatic t_standby_rd();
        wq.delete();
        wbyte(F_S, DEV_WR_ADDR, 1'b0);
        wbyte(8'h00, 8'h05, 1'b0);
        wbyte(F_P, 8'h77, 1'b0);
        chk("lp_ignored", 32'(wq.size()), 32'h0000_0000);
        wbyte(F_S, DEV_RD_ADDR, 1'b0);
        rbyte(F_N | F_P, RESTRICTED_READ_VAL);
        wbyte(F_S, DEV_WR_ADDR, 1'b0);
        wbyte(F_P, MASTER_CLOCK_CTRL_OFS, 1'b0);
        wbyte(F_S, DEV_RD_ADDR, 1'b0);
        rbyte(8'h00, 8'h55);
        rbyte(F_N | F_P, 8'h55);
        chk("lp_rd_count", 32'(wq.size()), 32'h0000_0000);
    endtask

    initial begin
        do_reset(1'b0);
        t_apb_map();
        t_bad_addr();
        t_write();
        t_read();
        t_standby();
        t_standby_rd();
        test_done();
    end

    initial begin
        repeat (90000) @(posedge clk);
        err_count++;
        test_done();
    end
endmodule
